// ### core/ebt_timer.sv
// 8-bit timer with one compare channel, waveform unit and APB registers
`timescale 1ns/10ps
module ebt_timer (
	input  wire logic                  ref_clk,
	input  wire logic                  sys_rst,
	input  wire ebt_pkg::ebt_apb_req_t apb_req,
	output      ebt_pkg::ebt_apb_rsp_t apb_rsp,
	output      ebt_pkg::ebt_pin_t     pin
);
	import ebt_pkg::*;

	// register file state
	logic [7:0]   ctrl_q;
	logic [7:0]   ctrl_d;
	logic [7:0]   cmp_buf_q;
	logic [7:0]   cmp_buf_d;
	logic [1:0]   stat_q;
	logic [1:0]   stat_d;
	logic [1:0]   port_q;
	logic [1:0]   port_d;
	ebt_bus_st_t  bus_q;
	ebt_bus_st_t  bus_d;
	ebt_apb_rsp_t rsp_q;
	ebt_apb_rsp_t rsp_d;

	// counter and waveform state
	logic [7:0]   cnt_q;
	logic [7:0]   cnt_d;
	logic [7:0]   cmp_act_q;
	logic [7:0]   cmp_act_d;
	logic         down_q;
	logic         down_d;
	logic         oc_q;
	logic         oc_d;
	logic         block_q;
	logic         block_d;
	ebt_pin_t     pin_q;
	ebt_pin_t     pin_d;

	// decoded controls and events
	logic         timer_tick;
	ebt_mode_t    wave_mode_select;
	logic [1:0]   compare_output_action;
	logic [1:0]   new_action;
	logic         pwm;
	logic         access;
	logic         wr_go;
	logic         wr_ctrl;
	logic         wr_cnt;
	logic         wr_cmp;
	logic         wr_stat;
	logic         wr_port;
	logic         hit;
	logic [31:0]  rdata;
	logic         force_go;
	logic         match;
	logic         at_top;
	logic         ovf_ev;
	logic         cmp_ev;
	logic [7:0]   cmp_next;

	// non-PWM compare action on the output latch
	function automatic logic act_nonpwm(input logic cur, input logic [1:0] a);
		logic r;
		r = cur;
		case (a)
			2'b01: r = ~cur;
			2'b10: r = 1'b0;
			2'b11: r = 1'b1;
			default: r = cur;
		endcase
		return r;
	endfunction : act_nonpwm

	// tick source
	ebt_prescaler #(
		.PRE_W(PRE_W)
	) u_prescaler (
		.ref_clk              (ref_clk),
		.sys_rst              (sys_rst),
		.clock_prescale_select(ctrl_q[CTL_CS_HI:0]),
		.timer_tick           (timer_tick)
	);

	// field decode and bus strobes
	assign wave_mode_select = ebt_mode_t'({ctrl_q[CTL_MODE_HI], ctrl_q[CTL_MODE_LO]});
	assign compare_output_action = ctrl_q[CTL_ACT_HI:CTL_ACT_LO];
	assign new_action = apb_req.pwdata[CTL_ACT_HI:CTL_ACT_LO];
	assign pwm = ctrl_q[CTL_MODE_LO];
	assign access = apb_req.psel & apb_req.penable;
	assign wr_go = access & rsp_q.pready & apb_req.pwrite;
	assign wr_ctrl = wr_go && apb_req.paddr == OFF_CTRL;
	assign wr_cnt = wr_go && apb_req.paddr == OFF_COUNT;
	assign wr_cmp = wr_go && apb_req.paddr == OFF_CMP;
	assign wr_stat = wr_go && apb_req.paddr == OFF_STAT;
	assign wr_port = wr_go && apb_req.paddr == OFF_PORT;
	// strobe only counts when the written mode is non-PWM
	assign force_go = wr_ctrl & apb_req.pwdata[CTL_FORCE]
		& ~apb_req.pwdata[CTL_MODE_LO];
	// compare value including this cycle's bus write, kept out of the bus process
	assign cmp_next = wr_cmp ? apb_req.pwdata[7:0] : cmp_buf_q;

	// read mux and address decode
	always_comb begin
		hit = 1'b1;
		rdata = 32'h0000_0000;
		case (apb_req.paddr)
			OFF_CTRL: rdata = {24'h00_0000, 1'b0, ctrl_q[6:0]};
			OFF_COUNT: rdata = {24'h00_0000, cnt_q};
			OFF_CMP: rdata = {24'h00_0000, cmp_buf_q};
			OFF_STAT: rdata = {30'h0000_0000, stat_q};
			OFF_PORT: rdata = {30'h0000_0000, port_q};
			default: hit = 1'b0;
		endcase
	end

	// APB slave and register writes
	always_comb begin
		bus_d = bus_q;
		rsp_d = rsp_q;
		ctrl_d = ctrl_q;
		cmp_buf_d = cmp_buf_q;
		port_d = port_q;
		stat_d = stat_q;
		case (bus_q)
			BUS_IDLE: begin
				if (access) begin
					bus_d = BUS_ACK;
					rsp_d.pready = 1'b1;
					rsp_d.pslverr = ~hit;
					rsp_d.prdata = rdata;
				end
			end
			BUS_ACK: begin
				bus_d = BUS_IDLE;
				rsp_d.pready = 1'b0;
				rsp_d.pslverr = 1'b0;
			end
			default: begin
				bus_d = BUS_IDLE;
				rsp_d.pready = 1'b0;
			end
		endcase
		if (wr_ctrl) begin
			ctrl_d = {1'b0, apb_req.pwdata[6:0]};
		end
		if (wr_cmp) begin
			cmp_buf_d = apb_req.pwdata[7:0];
		end
		if (wr_port) begin
			port_d = apb_req.pwdata[1:0];
		end
		// write one clears, a new event in the same cycle wins
		if (wr_stat) begin
			stat_d = stat_q & ~apb_req.pwdata[1:0];
		end
		if (ovf_ev) begin
			stat_d[STAT_OVF] = 1'b1;
		end
		if (cmp_ev) begin
			stat_d[STAT_CMP] = 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			bus_q     <= BUS_IDLE;
			rsp_q     <= '0;
			ctrl_q    <= CTRL_RST;
			cmp_buf_q <= CMP_RST;
			port_q    <= PORT_RST;
			stat_q    <= STAT_RST;
		end else begin
			bus_q     <= bus_d;
			rsp_q     <= rsp_d;
			ctrl_q    <= ctrl_d;
			cmp_buf_q <= cmp_buf_d;
			port_q    <= port_d;
			stat_q    <= stat_d;
		end
	end

	// counter, compare and waveform unit
	always_comb begin
		cnt_d = cnt_q;
		down_d = down_q;
		oc_d = oc_q;
		block_d = block_q;
		cmp_act_d = cmp_act_q;
		match = 1'b0;
		at_top = 1'b0;
		ovf_ev = 1'b0;
		cmp_ev = 1'b0;
		// compare writes land at once outside PWM
		if (!pwm) begin
			cmp_act_d = cmp_next;
		end
		if (timer_tick) begin
			block_d = 1'b0;
			match = cnt_q == cmp_act_q && !block_q;
			cmp_ev = match;
			case (wave_mode_select)
				MODE_NORMAL: begin
					cnt_d = cnt_q + 8'h01;
					ovf_ev = cnt_q == TOP_MAX;
					if (match) begin
						oc_d = act_nonpwm(oc_q, compare_output_action);
					end
				end
				MODE_CLEAR: begin
					// top is the compare value
					cnt_d = match ? BOTTOM : cnt_q + 8'h01;
					ovf_ev = cnt_q == TOP_MAX;
					if (match) begin
						oc_d = act_nonpwm(oc_q, compare_output_action);
					end
				end
				MODE_FAST: begin
					cnt_d = cnt_q + 8'h01;
					at_top = cnt_q == TOP_MAX;
					ovf_ev = at_top;
					if (match && compare_output_action[1] && cmp_act_q != TOP_MAX) begin
						oc_d = compare_output_action[0];
					end
					if (at_top) begin
						cmp_act_d = cmp_next;
						if (compare_output_action[1]) begin
							oc_d = ~compare_output_action[0];
						end
					end
				end
				MODE_PHASE: begin
					at_top = !down_q && cnt_q == TOP_MAX;
					if (at_top) begin
						down_d = 1'b1;
						cnt_d = cnt_q - 8'h01;
					end else if (down_q && cnt_q == BOTTOM) begin
						down_d = 1'b0;
						cnt_d = cnt_q + 8'h01;
						ovf_ev = 1'b1;
					end else if (down_q) begin
						cnt_d = cnt_q - 8'h01;
					end else begin
						cnt_d = cnt_q + 8'h01;
					end
					if (match && compare_output_action[1] && cmp_act_q != TOP_MAX) begin
						oc_d = down_q ? ~compare_output_action[0]
							: compare_output_action[0];
					end
					if (at_top) begin
						cmp_act_d = cmp_next;
						if (compare_output_action[1] && cmp_act_q == TOP_MAX) begin
							oc_d = ~compare_output_action[0];
						end
					end
				end
				default: cnt_d = cnt_q;
			endcase
			if (wave_mode_select != MODE_PHASE) begin
				down_d = 1'b0;
			end
		end
		// forced compare: pin only, no flag, no clear
		if (force_go) begin
			oc_d = act_nonpwm(oc_q, new_action);
		end
		// a software count write wins and masks the next match
		if (wr_cnt) begin
			cnt_d = apb_req.pwdata[7:0];
			block_d = 1'b1;
		end
	end

	// compare output takes the pin data over any nonzero action, the driver enable stays with port control
	always_comb begin
		pin_d.out = compare_output_action != 2'b00 ? oc_q : port_q[PORT_DATA];
		pin_d.oe = port_q[PORT_DIR];
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			cnt_q     <= COUNT_RST;
			cmp_act_q <= CMP_RST;
			down_q    <= 1'b0;
			oc_q      <= 1'b0;
			block_q   <= 1'b0;
			pin_q     <= '0;
		end else begin
			cnt_q     <= cnt_d;
			cmp_act_q <= cmp_act_d;
			down_q    <= down_d;
			oc_q      <= oc_d;
			block_q   <= block_d;
			pin_q     <= pin_d;
		end
	end

	assign apb_rsp = rsp_q;
	assign pin = pin_q;
endmodule : ebt_timer

// ### common/ebt_pkg.sv
// package: register map, field layout, reset values and types of the 8-bit timer
package ebt_pkg;
	// register byte offsets
	localparam logic [7:0] OFF_CTRL  = 8'h00;
	localparam logic [7:0] OFF_COUNT = 8'h04;
	localparam logic [7:0] OFF_CMP   = 8'h08;
	localparam logic [7:0] OFF_STAT  = 8'h0C;
	localparam logic [7:0] OFF_PORT  = 8'h10;
	// waveform_control field positions
	localparam int CTL_FORCE   = 7;
	localparam int CTL_MODE_LO = 6;
	localparam int CTL_ACT_HI  = 5;
	localparam int CTL_ACT_LO  = 4;
	localparam int CTL_MODE_HI = 3;
	localparam int CTL_CS_HI   = 2;
	// status and port control field positions
	localparam int STAT_OVF  = 0;
	localparam int STAT_CMP  = 1;
	localparam int PORT_DIR  = 0;
	localparam int PORT_DATA = 1;
	// reset values
	localparam logic [7:0] CTRL_RST  = 8'h00;
	localparam logic [7:0] COUNT_RST = 8'h00;
	localparam logic [7:0] CMP_RST   = 8'h00;
	localparam logic [1:0] STAT_RST  = 2'h0;
	localparam logic [1:0] PORT_RST  = 2'h0;
	// counter limits
	localparam logic [7:0] TOP_MAX = 8'hFF;
	localparam logic [7:0] BOTTOM  = 8'h00;
	// prescaler taps, as bit counts of the divider
	localparam int PRE_W      = 10;
	localparam int DIV8_BITS  = 3;
	localparam int DIV32_BITS = 5;
	localparam int DIV64_BITS = 6;
	localparam int DIV128_BITS = 7;
	localparam int DIV256_BITS = 8;
	localparam int DIV1K_BITS = 10;

	typedef enum logic [1:0] {
		MODE_NORMAL = 2'b00,
		MODE_PHASE  = 2'b01,
		MODE_CLEAR  = 2'b10,
		MODE_FAST   = 2'b11
	} ebt_mode_t;

	typedef enum logic {
		BUS_IDLE = 1'b0,
		BUS_ACK  = 1'b1
	} ebt_bus_st_t;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} ebt_apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} ebt_apb_rsp_t;

	typedef struct packed {
		logic out;
		logic oe;
	} ebt_pin_t;
endpackage : ebt_pkg

// ### core/ebt_prescaler.sv
// prescaler: free-running divider giving the selected timer tick enable
`timescale 1ns/10ps
module ebt_prescaler #(
	parameter int PRE_W = 10
)(
	input  wire logic       ref_clk,
	input  wire logic       sys_rst,
	input  wire logic [2:0] clock_prescale_select,
	output      logic       timer_tick
);
	import ebt_pkg::*;

	logic [PRE_W-1:0] div_q;
	logic [PRE_W-1:0] div_d;
	logic             tick_q;
	logic             tick_d;

	// divider count and tap selection
	always_comb begin
		div_d = div_q + {{(PRE_W-1){1'b0}}, 1'b1};
		case (clock_prescale_select)
			3'h0: tick_d = 1'b0;
			3'h1: tick_d = 1'b1;
			3'h2: tick_d = &div_q[DIV8_BITS-1:0];
			3'h3: tick_d = &div_q[DIV32_BITS-1:0];
			3'h4: tick_d = &div_q[DIV64_BITS-1:0];
			3'h5: tick_d = &div_q[DIV128_BITS-1:0];
			3'h6: tick_d = &div_q[DIV256_BITS-1:0];
			3'h7: tick_d = &div_q[DIV1K_BITS-1:0];
			default: tick_d = 1'b0;
		endcase
	end

	// register the divider and the tick
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			div_q  <= '0;
			tick_q <= 1'b0;
		end else begin
			div_q  <= div_d;
			tick_q <= tick_d;
		end
	end

	assign timer_tick = tick_q;
endmodule : ebt_prescaler

// ### verification/ebt_timer_checker.sv
// checker: bus answer and read-back properties of the timer block
`timescale 1ns/10ps
module ebt_timer_checker (
	input wire logic                  ref_clk,
	input wire logic                  sys_rst,
	input wire ebt_pkg::ebt_apb_req_t apb_req,
	input wire ebt_pkg::ebt_apb_rsp_t apb_rsp,
	input wire ebt_pkg::ebt_pin_t     pin
);
	import ebt_pkg::*;
	logic mapped;
	logic port_wr;
	logic rd_ctl;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	// decode of the current request
	assign mapped  = apb_req.paddr inside {OFF_CTRL, OFF_COUNT, OFF_CMP, OFF_STAT, OFF_PORT};
	assign port_wr = apb_rsp.pready && apb_req.pwrite && apb_req.paddr == OFF_PORT;
	assign rd_ctl  = apb_rsp.pready && !apb_req.pwrite && apb_req.paddr == OFF_CTRL;
	ready_after_access_a: assert property (apb_req.psel && apb_req.penable
		&& !$past(apb_req.penable) |=> apb_rsp.pready) else $error("ready late");
	ready_pulse_a: assert property (apb_rsp.pready |=> !apb_rsp.pready)
		else $error("ready held");
	ready_in_access_a: assert property (apb_rsp.pready |-> apb_req.psel && apb_req.penable)
		else $error("ready outside access");
	unmapped_error_a: assert property (apb_rsp.pready && !mapped
		|-> apb_rsp.pslverr && apb_rsp.prdata == 32'h0) else $error("unmapped not refused");
	mapped_ok_a: assert property (apb_rsp.pready && mapped
		|-> !apb_rsp.pslverr && apb_rsp.prdata[31:8] == 24'h0) else $error("mapped read bad");
	force_reads_zero_a: assert property (rd_ctl |-> !apb_rsp.prdata[CTL_FORCE])
		else $error("force bit read high");
	error_with_ready_a: assert property (apb_rsp.pslverr |-> apb_rsp.pready)
		else $error("error without ready");
	oe_cause_a: assert property ($changed(pin.oe) |-> $past(port_wr) || $past(port_wr, 2))
		else $error("driver enable moved alone");
endmodule : ebt_timer_checker

bind ebt_timer ebt_timer_checker u_chk (.ref_clk(ref_clk), .sys_rst(sys_rst),
	.apb_req(apb_req), .apb_rsp(apb_rsp), .pin(pin));

// ### verification/eight_bit_timer_waveform_regs_test.sv
// testbench: registers, prescaler, match and forced compare of the timer
`timescale 1ns/10ps
module eight_bit_timer_waveform_regs_test;
	import ebt_pkg::*;
	logic         ref_clk;
	logic         sys_rst;
	ebt_apb_req_t req;
	ebt_apb_rsp_t rsp;
	ebt_pin_t     pin;
	logic [31:0]  rdat;
	logic         rerr;
	int           n_errors = 0;
	int           checks = 0;
	int           cycles = 0;
	int           m_pin;
	int           c0;
	int           v;
	int           per [8] = '{16, 1, 8, 32, 64, 128, 256, 1024};
	ebt_timer u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .apb_req(req), .apb_rsp(rsp),
		.pin(pin));
	// clock
	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	// hang guard
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_errors++;
			results();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	// one apb transfer, waits for pready, then one idle cycle
	task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
		req <= '{1'b1, 1'b0, w, a, d};
		@(posedge ref_clk);
		req.penable <= 1'b1;
		do @(posedge ref_clk); while (rsp.pready !== 1'b1);
		rdat = rsp.prdata;
		rerr = rsp.pslverr;
		req <= '0;
		@(posedge ref_clk);
	endtask : acc
	function automatic logic [31:0] ctl(input int md, input int ac, input int cs, input int f);
		ctl = 32'(f << CTL_FORCE | (md & 1) << CTL_MODE_LO | ac << CTL_ACT_LO
			| (md >> 1) << CTL_MODE_HI | cs);
	endfunction : ctl
	// rule model of the compare pin in pwm: high ticks in one steady period
	function automatic int pwm_high(input int md, input int act, input int c);
		int len;
		int n;
		int up;
		int pm;
		int hi;
		len = md == 3 ? 256 : 510;
		pm = 0;
		hi = 0;
		for (int i = 0; i < 2 * len; i++) begin
			n = md == 3 ? i % len : (i % len <= 255 ? i % len : len - i % len);
			up = md == 3 || (i % len >= 1 && i % len <= 255);
			if (n == c && c != 255)
				pm = up ? act & 1 : 1 - (act & 1);
			if (n == 255 && (md == 3 || c == 255))
				pm = 1 - (act & 1);
			if (i >= len)
				hi += pm;
		end
		return hi;
	endfunction : pwm_high
	task automatic results();
		$display("checks %0d n_errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : results
	// main sequence
	initial begin
		sys_rst = 1'b1;
		req = '0;
		v = $urandom(32'he9d0);
		repeat (20) @(posedge ref_clk);
		sys_rst <= 1'b0;
		@(posedge ref_clk);
		for (int a = 0; a <= 16; a += 4) begin
			acc(1'b0, 8'(a), 32'h0);
			chk(rdat, 32'h0);
		end
		acc(1'b0, 8'h14, 32'h0);
		chk(32'(rerr), 32'h1);
		// strobe never reads back
		v = $urandom_range(3, 0);
		acc(1'b1, OFF_CTRL, ctl(3, v, 0, 1));
		acc(1'b0, OFF_CTRL, 32'h0);
		chk(rdat, ctl(3, v, 0, 0));
		// ticks over a window of four tick periods per select
		for (int s = 0; s < 8; s++) begin
			acc(1'b1, OFF_CTRL, ctl(0, 0, s, 0));
			acc(1'b0, OFF_COUNT, 32'h0);
			c0 = rdat;
			repeat (4 * per[s] - 4) @(posedge ref_clk);
			acc(1'b0, OFF_COUNT, 32'h0);
			chk(rdat, 32'((c0 + (s == 0 ? 0 : 4)) & 255));
		end
		acc(1'b1, OFF_CTRL, ctl(0, 0, 0, 0));
		v = $urandom_range(250, 20);
		acc(1'b1, OFF_COUNT, v);
		acc(1'b1, OFF_CMP, v ^ 8'h5A);
		acc(1'b0, OFF_COUNT, 0);
		chk(rdat, v);
		acc(1'b0, OFF_CMP, 0);
		chk(rdat, v ^ 8'h5A);
		// counter write hides the next match, later match and wrap flag
		acc(1'b1, OFF_CMP, v);
		acc(1'b1, OFF_COUNT, v ^ 8'h80);
		acc(1'b1, OFF_CTRL, ctl(0, 0, 1, 0));
		acc(1'b1, OFF_STAT, 3);
		acc(1'b1, OFF_COUNT, v);
		acc(1'b0, OFF_STAT, 0);
		chk(32'(rdat[STAT_CMP]), 0);
		repeat (260) @(posedge ref_clk);
		acc(1'b0, OFF_STAT, 0);
		chk(rdat, 3);
		// clear-on-match keeps the counter at or below compare
		acc(1'b1, OFF_CTRL, ctl(2, 0, 1, 0));
		repeat (300) @(posedge ref_clk);
		acc(1'b0, OFF_COUNT, 0);
		chk(32'(rdat <= v), 1);
		// forced compares with the counter stopped
		acc(1'b1, OFF_CTRL, ctl(2, 0, 0, 0));
		acc(1'b1, OFF_PORT, 1);
		acc(1'b1, OFF_COUNT, v);
		acc(1'b1, OFF_STAT, 3);
		m_pin = 0;
		for (int k = 0; k < 4; k++) begin
			c0 = k == 0 ? 3 : (k == 1 ? 2 : 1);
			acc(1'b1, OFF_CTRL, ctl(2, c0, 0, 1));
			m_pin = c0 == 3 ? 1 : (c0 == 2 ? 0 : 1 - m_pin);
			@(posedge ref_clk);
			chk(32'({pin.oe, pin.out}), 32'(2 + m_pin));
		end
		acc(1'b0, OFF_COUNT, 0);
		chk(rdat, v);
		acc(1'b0, OFF_STAT, 0);
		chk(rdat, 0);
		// both pwm modes ignore the strobe
		for (int md = 1; md < 4; md += 2) begin
			acc(1'b1, OFF_CTRL, ctl(md, 3, 0, 1));
			@(posedge ref_clk);
			chk(32'(pin.out), 0);
		end
		// pwm duty over two periods against the model, random and top compare
		for (int md = 3; md > 0; md -= 2) begin
			for (int k = 0; k < 2; k++) begin
				c0 = k == 0 ? $urandom_range(254, 1) : 255;
				v = 2 + $urandom_range(1, 0);
				acc(1'b1, OFF_CTRL, ctl(0, 0, 0, 0));
				acc(1'b1, OFF_CMP, c0);
				acc(1'b1, OFF_CTRL, ctl(md, v, 1, 0));
				repeat (520) @(posedge ref_clk);
				m_pin = 0;
				repeat (md == 3 ? 512 : 1020) begin
					@(posedge ref_clk);
					m_pin += (pin.out === 1'b1);
				end
				chk(m_pin, 2 * pwm_high(md, v, c0));
			end
		end
		results();
	end
endmodule : eight_bit_timer_waveform_regs_test
